// [rtl/mrps_top.sv]
// Purpose: mac-facing status outputs, rmii 10 Mb sfd gating, strap latch
//          and routing of interrupt and power-event onto shared pins
// Assumes: rx_i, tx_en_i and friends come from logic on hclk; straps,
//          the system reset pin and the tx error pin are asynchronous
// Notes: ahb-lite slave, writes zero wait, reads one wait state
//
// Functional notes
// - mii mode raises collision output while a medium collision is seen
// - rmii 10 Mb half duplex never loops own transmit onto rxd
// - mii mode drives carrier sense while a carrier is detected
// - straps sampled at power-on and each system reset, then held
// - default operating mode from three held mode strap bits
// - indicator a shows activity, speed, irq or pme per select field
// - interrupt active low, on shared pin by default, or on indicators
// - active-low power event, routable to indicators or, in rmii mode only, rxd2 pin
// - regulator-off strap high disables the core regulator
// - interface strap low selects mii, high selects rmii
// - irq strap high: shared pin is irq; low: tx error input
`timescale 1ns/1ns
module mrps_top #(
   parameter int DATA_W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [DATA_W-1:0] hwdata,
   output logic [DATA_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sys_rst_pin_n,
   input wire mrps_pkg::mrps_strap_t strap_pins,
   input wire mrps_pkg::mrps_rx_t rx_i,
   input wire logic tx_en_i,
   input wire logic half_duplex_i,
   input wire logic link_act_i,
   input wire logic link_speed_i,
   input wire logic pme_req_i,
   input wire logic tx_symbol_bit4_pin,
   output logic mii_col,
   output logic mii_crs,
   output logic crs_dv,
   output logic [3:0] rxd,
   output logic strap_pins_oe,
   output logic indicator_out_a,
   output logic indicator_out_b,
   output logic irq_out_n,
   output logic irq_pin_o,
   output logic irq_pin_oe,
   output logic tx_symbol_bit4,
   output logic power_event_out_n,
   output logic core_regulator_off,
   output logic rmii_mode,
   output logic [2:0] opmode,
   output logic irq
);

   // the bus model and field packing assume a 32-bit data path
   if (DATA_W != 32)
   begin : g_chk
      $error("mrps_top: DATA_W must be 32");
   end

   // indicator function mux, shared by both indicator pins
   function automatic logic led_drive(
      input mrps_pkg::mrps_led_fsel_t fsel,
      input logic act,
      input logic spd,
      input logic irqn,
      input logic pmen);
      logic v;
      v = act;
      unique case (fsel)
         mrps_pkg::LED_ACT: v = act;
         mrps_pkg::LED_SPEED: v = spd;
         mrps_pkg::LED_IRQ: v = irqn;
         mrps_pkg::LED_PME: v = pmen;
      endcase
      return v;
   endfunction : led_drive

   logic srst_q1_ff;
   logic srst_q2_ff;
   logic srst_prev_ff;
   mrps_pkg::mrps_strap_t strap_q1_ff;
   mrps_pkg::mrps_strap_t strap_q2_ff;
   mrps_pkg::mrps_strap_t strap_ff;
   logic tx_symbol_bit4_q1_ff;
   logic tx_symbol_bit4_q2_ff;
   logic por_done_ff;
   mrps_pkg::mrps_ctrl_t ctrl_ff;
   logic [mrps_pkg::ST_W-1:0] stat_ff;
   logic [mrps_pkg::ST_W-1:0] mask_ff;
   logic [7:0] a_ff;
   logic wr_ff;
   logic rd_ff;
   logic [DATA_W-1:0] hrdata_ff;
   logic hreadyout_ff;
   logic [7:0] sfd_sr_ff;
   logic sfd_seen_ff;
   logic col_ff;
   logic crs_ff;
   logic crs_dv_ff;
   logic [3:0] rxd_ff;
   logic pins_oe_ff;
   logic led_a_ff;
   logic led_b_ff;
   logic irq_n_ff;
   logic irq_pin_o_ff;
   logic irq_pin_oe_ff;
   logic tx_symbol_bit4_ff;
   logic pme_n_ff;
   logic irq_ff;

   // system reset pin and straps cross in through two flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         srst_q1_ff <= 1'b0;
         srst_q2_ff <= 1'b0;
         strap_q1_ff <= mrps_pkg::STRAP_RST;
         strap_q2_ff <= mrps_pkg::STRAP_RST;
         tx_symbol_bit4_q1_ff <= 1'b0;
         tx_symbol_bit4_q2_ff <= 1'b0;
      end
      else
      begin
         srst_q1_ff <= sys_rst_pin_n;
         srst_q2_ff <= srst_q1_ff;
         strap_q1_ff <= strap_pins;
         strap_q2_ff <= strap_q1_ff;
         tx_symbol_bit4_q1_ff <= tx_symbol_bit4_pin;
         tx_symbol_bit4_q2_ff <= tx_symbol_bit4_q1_ff;
      end
   end

   // strap capture window: power-on and all of a system reset, plus one
   // cycle so the sync chain has flushed its reset value; the last
   // sample taken in the window is what is held
   wire in_sreset = !srst_q2_ff;
   wire capture = !por_done_ff || in_sreset || !srst_prev_ff;
   wire quiet = capture;
   wire strap_done = (!por_done_ff) || (srst_q2_ff && !srst_prev_ff);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         por_done_ff <= 1'b0;
         srst_prev_ff <= 1'b0;
         strap_ff <= mrps_pkg::STRAP_RST;
      end
      else
      begin
         por_done_ff <= 1'b1;
         srst_prev_ff <= srst_q2_ff;
         if (capture)
            strap_ff <= strap_q2_ff;
      end
   end

   // mode decode from the held straps
   wire is_rmii = strap_ff.reduced_interface_select_strap;
   wire irq_on_pin = strap_ff.irq_pin_function_strap;

   // ahb-lite address phase qualification
   wire a_take = hsel && htrans[1] && hready;
   wire w_ctrl = wr_ff && (a_ff == mrps_pkg::OFS_CTRL);
   wire w_stat = wr_ff && (a_ff == mrps_pkg::OFS_STAT);
   wire w_mask = wr_ff && (a_ff == mrps_pkg::OFS_MASK);

   // read mux; unmapped offsets read as zero
   wire [DATA_W-1:0] rd_ctrl = {27'h0000000, ctrl_ff};
   wire [DATA_W-1:0] rd_stat = {28'h0000000, stat_ff};
   wire [DATA_W-1:0] rd_mask = {28'h0000000, mask_ff};
   wire [DATA_W-1:0] rd_strap = {24'h000000, col_ff, crs_ff, strap_ff};
   wire [DATA_W-1:0] rd_word =
      (a_ff == mrps_pkg::OFS_CTRL) ? rd_ctrl :
      (a_ff == mrps_pkg::OFS_STAT) ? rd_stat :
      (a_ff == mrps_pkg::OFS_MASK) ? rd_mask :
      (a_ff == mrps_pkg::OFS_STRAP) ? rd_strap : 32'h00000000;

   // a read holds hreadyout low for one cycle so the word is registered
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_ff <= 8'h00;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         hreadyout_ff <= 1'b1;
         hrdata_ff <= 32'h00000000;
      end
      else
      begin
         if (hready)
         begin
            a_ff <= haddr[7:0];
            wr_ff <= a_take && hwrite;
            rd_ff <= a_take && !hwrite;
         end
         if (a_take && !hwrite)
            hreadyout_ff <= 1'b0;
         else if (rd_ff && !hreadyout_ff)
         begin
            hreadyout_ff <= 1'b1;
            hrdata_ff <= rd_word;
         end
      end
   end

   // sfd search on the rmii dibit stream, first bit is rxd bit 0
   wire rx_go = is_rmii && rx_i.non_idle && !quiet;
   wire [7:0] nxt_sfd_sr = {sfd_sr_ff[5:0], rx_i.nib[0], rx_i.nib[1]};
   wire sfd_hit = rx_go && rx_i.ten_mb && !sfd_seen_ff
      && (nxt_sfd_sr == mrps_pkg::SFD_BYTE);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sfd_sr_ff <= 8'h00;
         sfd_seen_ff <= 1'b0;
      end
      else if (!rx_go)
      begin
         sfd_sr_ff <= 8'h00; // the search restarts on every frame
         sfd_seen_ff <= 1'b0;
      end
      else
      begin
         sfd_sr_ff <= nxt_sfd_sr;
         if (sfd_hit)
            sfd_seen_ff <= 1'b1;
      end
   end

   // receive output selection; the dibit that completes the sfd is
   // itself still held low, data flows from the next one
   wire hold10 = rx_i.ten_mb && !sfd_seen_ff;
   wire echo = rx_i.ten_mb && half_duplex_i && tx_en_i;
   wire rm_pass = rx_go && !hold10 && !echo;
   wire [1:0] rm_dibit = rm_pass ? rx_i.nib[1:0] : 2'b00;
   wire pme_n = !pme_req_i;
   wire rm_bit2 = ctrl_ff.pme_on_rxd2 ? pme_n_ff : 1'b0;
   wire [3:0] mii_nib = quiet ? 4'h0 : rx_i.nib;
   wire [3:0] nxt_rxd = is_rmii ? {1'b0, rm_bit2, rm_dibit} : mii_nib;

   // status pins toward the mac
   wire nxt_col = !is_rmii && !quiet && rx_i.collision;
   wire nxt_crs = !is_rmii && !quiet && rx_i.carrier;
   wire nxt_crs_dv = rx_go;

   // events: rising collision, rising carrier, sfd found, straps held
   wire ev_crs = (is_rmii ? nxt_crs_dv && !crs_dv_ff : nxt_crs && !crs_ff);
   wire [mrps_pkg::ST_W-1:0] ev;
   assign ev[mrps_pkg::ST_COL] = nxt_col && !col_ff;
   assign ev[mrps_pkg::ST_CRS] = ev_crs;
   assign ev[mrps_pkg::ST_SFD] = sfd_hit;
   assign ev[mrps_pkg::ST_STRAP] = strap_done;

   // write-one-to-clear; an event in the clearing cycle still sets
   wire [mrps_pkg::ST_W-1:0] st_clr =
      w_stat ? hwdata[mrps_pkg::ST_W-1:0] : 4'h0;
   wire [mrps_pkg::ST_W-1:0] nxt_stat = (stat_ff & ~st_clr) | ev;
   wire nxt_irq = |(nxt_stat & mask_ff);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_ff <= mrps_pkg::CTRL_RST;
         stat_ff <= mrps_pkg::STAT_RST;
         mask_ff <= mrps_pkg::MASK_RST;
      end
      else
      begin
         stat_ff <= nxt_stat;
         if (w_ctrl)
            ctrl_ff <= hwdata[4:0];
         if (w_mask)
            mask_ff <= hwdata[mrps_pkg::ST_W-1:0];
      end
   end

   // indicators pick their source from the wakeup control field
   wire nxt_led_a = led_drive(ctrl_ff.led_a, link_act_i, link_speed_i,
      irq_n_ff, pme_n_ff);
   wire nxt_led_b = led_drive(ctrl_ff.led_b, link_act_i, link_speed_i,
      irq_n_ff, pme_n_ff);

   // mac-facing pins; shared strap pins stay undriven while straps
   // are sampled so the external resistors set the level
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         col_ff <= 1'b0;
         crs_ff <= 1'b0;
         crs_dv_ff <= 1'b0;
         rxd_ff <= 4'h0;
         pins_oe_ff <= 1'b0;
      end
      else
      begin
         col_ff <= nxt_col;
         crs_ff <= nxt_crs;
         crs_dv_ff <= nxt_crs_dv;
         rxd_ff <= nxt_rxd;
         pins_oe_ff <= !quiet;
      end
   end

   // interrupt, power event, shared pin and indicator drivers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_ff <= 1'b0;
         irq_n_ff <= 1'b1;
         irq_pin_o_ff <= 1'b1;
         irq_pin_oe_ff <= 1'b0;
         tx_symbol_bit4_ff <= 1'b0;
         pme_n_ff <= 1'b1;
         led_a_ff <= 1'b0;
         led_b_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= nxt_irq;
         irq_n_ff <= !nxt_irq;
         irq_pin_o_ff <= !nxt_irq;
         irq_pin_oe_ff <= irq_on_pin && !quiet;
         tx_symbol_bit4_ff <= irq_on_pin ? 1'b0 : tx_symbol_bit4_q2_ff;
         pme_n_ff <= pme_n;
         led_a_ff <= nxt_led_a;
         led_b_ff <= nxt_led_b;
      end
   end

   // bus outputs; every response is okay
   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = 1'b0;

   // pin outputs, all straight from flops
   assign mii_col = col_ff;
   assign mii_crs = crs_ff;
   assign crs_dv = crs_dv_ff;
   assign rxd = rxd_ff;
   assign strap_pins_oe = pins_oe_ff;
   assign indicator_out_a = led_a_ff;
   assign indicator_out_b = led_b_ff;
   assign irq_out_n = irq_n_ff;
   assign irq_pin_o = irq_pin_o_ff;
   assign irq_pin_oe = irq_pin_oe_ff;
   assign tx_symbol_bit4 = tx_symbol_bit4_ff;
   assign power_event_out_n = pme_n_ff;
   assign irq = irq_ff;

   // held strap values; regulator stays on unless the strap was high
   assign core_regulator_off = strap_ff.core_regulator_disable_strap;
   assign rmii_mode = strap_ff.reduced_interface_select_strap;
   assign opmode = {strap_ff.opmode_strap_bit2, strap_ff.opmode_strap_bit1,
      strap_ff.opmode_strap_bit0};

endmodule : mrps_top

// [shared/mrps_pkg.sv]
// Purpose: constants and types for the mii/rmii status and pin select block
// Assumes: 32-bit ahb-lite register window, one word per register
// Notes: byte offsets, field positions and reset values live here only
package mrps_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_STRAP = 8'h0C;

   // sticky status bit positions
   localparam int ST_COL = 0;
   localparam int ST_CRS = 1;
   localparam int ST_SFD = 2;
   localparam int ST_STRAP = 3;
   localparam int ST_W = 4;

   // strap register: live state bits above the held straps
   localparam int SR_CRS = 6;
   localparam int SR_COL = 7;

   // start-of-frame delimiter, first received bit in the msb
   localparam logic [7:0] SFD_BYTE = 8'hAB;

   // indicator function select codes
   typedef enum logic [1:0] {
      LED_ACT,
      LED_SPEED,
      LED_IRQ,
      LED_PME
   } mrps_led_fsel_t;

   // wakeup_ctrl_status_reg layout
   typedef struct packed {
      logic pme_on_rxd2;
      mrps_led_fsel_t led_b;
      mrps_led_fsel_t led_a;
   } mrps_ctrl_t;

   // configuration straps as sampled from the pins
   typedef struct packed {
      logic irq_pin_function_strap;
      logic core_regulator_disable_strap;
      logic reduced_interface_select_strap;
      logic opmode_strap_bit2;
      logic opmode_strap_bit1;
      logic opmode_strap_bit0;
   } mrps_strap_t;

   // receive-side indications from the line decoder
   typedef struct packed {
      logic non_idle;
      logic carrier;
      logic collision;
      logic ten_mb;
      logic [3:0] nib;
   } mrps_rx_t;

   localparam logic [4:0] CTRL_RST = 5'h04;
   localparam logic [ST_W-1:0] STAT_RST = 4'h0;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;
   localparam logic [5:0] STRAP_RST = 6'h27;

endpackage : mrps_pkg

// [sim/mrps_chk_asserts.sv]
// Purpose: timing checks on the mac-facing pins and the register bus
// Assumes: one clock domain, pins meaningful while strap_pins_oe is up
// Notes: sees only mrps_top ports, bound at the foot of this file
`timescale 1ns/1ns
module mrps_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic sys_rst_pin_n,
   input wire mrps_pkg::mrps_rx_t rx_i,
   input wire logic tx_en_i,
   input wire logic half_duplex_i,
   input wire logic pme_req_i,
   input wire logic mii_col,
   input wire logic mii_crs,
   input wire logic crs_dv,
   input wire logic [3:0] rxd,
   input wire logic strap_pins_oe,
   input wire logic irq_out_n,
   input wire logic irq_pin_o,
   input wire logic irq_pin_oe,
   input wire logic power_event_out_n,
   input wire logic core_regulator_off,
   input wire logic rmii_mode,
   input wire logic [2:0] opmode,
   input wire logic irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // pins live: outside the strap window and no system reset seen
   sequence s_run;
      strap_pins_oe && sys_rst_pin_n;
   endsequence
   sequence s_rd;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   a_col_follows: assert property (s_run ##0 !rmii_mode && rx_i.collision |=> mii_col)
      else $error("collision not shown");
   a_crs_follows: assert property (s_run ##0 !rmii_mode && rx_i.carrier |=> mii_crs)
      else $error("carrier not shown");
   a_crsdv_busy: assert property (s_run ##0 rmii_mode && rx_i.non_idle |=> crs_dv)
      else $error("crs_dv low on busy medium");
   a_sfd_gate: assert property (s_run ##0 rmii_mode && rx_i.ten_mb
      && $rose(rx_i.non_idle) |=> (rxd[1:0] == 2'h0) [*4])
      else $error("rxd leaked before sfd");
   a_no_echo: assert property (s_run ##0 rmii_mode && rx_i.ten_mb
      && half_duplex_i && tx_en_i |=> rxd[1:0] == 2'h0)
      else $error("own transmit echoed");
   a_straps_held: assert property (s_run [*3]
      |-> $stable({opmode, rmii_mode, core_regulator_off}))
      else $error("held straps moved");
   a_irq_low: assert property (irq |-> !irq_out_n
      && (!irq_pin_oe || !irq_pin_o))
      else $error("interrupt not active low");
   a_pme_follows: assert property ($rose(pme_req_i) |=> !power_event_out_n)
      else $error("power event not low");
   a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
endmodule : mrps_chk

bind mrps_top mrps_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .sys_rst_pin_n, .rx_i, .tx_en_i, .half_duplex_i,
   .pme_req_i, .mii_col, .mii_crs, .crs_dv, .rxd, .strap_pins_oe,
   .irq_out_n, .irq_pin_o, .irq_pin_oe, .power_event_out_n,
   .core_regulator_off, .rmii_mode, .opmode, .irq);

// [sim/mrps_mac_model.sv]
// Purpose: mac side of the rmii link, collects received dibits
// Assumes: rmii mode, dibit bit 0 arrives first
// Notes: counts nonzero dibits so leaked preamble shows up
`timescale 1ns/1ns
module mrps_mac_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic crs_dv,
   input wire logic [3:0] rxd,
   input wire logic tx_go,
   output logic tx_en_i,
   output logic [7:0] last_byte,
   output int nz_dibits
);
   // shift in while the phy says the medium is busy
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_en_i <= 1'b0;
         last_byte <= 8'h00;
         nz_dibits <= 0;
      end
      else
      begin
         tx_en_i <= tx_go;
         if (crs_dv)
         begin
            last_byte <= {last_byte[5:0], rxd[0], rxd[1]};
            if (rxd[1:0] != 2'h0)
               nz_dibits <= nz_dibits + 1;
         end
      end
   end
endmodule : mrps_mac_model

// [sim/tb.sv]
// Purpose: self-checking bench for mrps_top
// Assumes: bus master waits on hreadyout, fixed random seed
// Notes: mii phase after power-on, rmii phase after system reset
`timescale 1ns/1ns
module tb;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize, opmode;
   logic sys_rst_pin_n, tx_en_i, half_duplex_i, link_act_i, link_speed_i;
   logic pme_req_i, tx_symbol_bit4_pin, mii_col, mii_crs, crs_dv, go, e;
   logic strap_pins_oe, indicator_out_a, indicator_out_b, irq_out_n;
   logic irq_pin_o, irq_pin_oe, tx_symbol_bit4, power_event_out_n;
   logic core_regulator_off, rmii_mode, irq;
   logic [3:0] rxd;
   logic [7:0] lb, d;
   mrps_pkg::mrps_strap_t strap_pins;
   mrps_pkg::mrps_rx_t rx_i;
   int nz, n0, bad_count, checks_done;
   assign hready = hreadyout;

   mrps_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready, .hwdata, .hrdata, .hreadyout, .hresp, .sys_rst_pin_n,
      .strap_pins, .rx_i, .tx_en_i, .half_duplex_i, .link_act_i,
      .link_speed_i, .pme_req_i, .tx_symbol_bit4_pin, .mii_col, .mii_crs,
      .crs_dv, .rxd, .strap_pins_oe, .indicator_out_a, .indicator_out_b,
      .irq_out_n, .irq_pin_o, .irq_pin_oe, .tx_symbol_bit4,
      .power_event_out_n, .core_regulator_off, .rmii_mode, .opmode, .irq);
   mrps_mac_model mac (.hclk, .hresetn, .crs_dv, .rxd, .tx_go(go),
      .tx_en_i, .last_byte(lb), .nz_dibits(nz));

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic print_verdict;
      if (bad_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   // one single transfer; wait on hready is bounded
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      r = hrdata;
      if (n >= 50)
      begin
         bad_count++;
         print_verdict();
      end
   endtask : xf

   // nonzero dibits a byte puts on rxd, first bit in the msb
   function automatic int nzd(input logic [7:0] b);
      int n;
      n = 0;
      for (int j = 0; j < 4; j++)
         if (b[7-2*j -: 2] != 2'h0)
            n++;
      return n;
   endfunction : nzd

   // 10 Mb frame: seven preamble bytes, delimiter, one data byte
   task automatic frm(input logic [7:0] v);
      logic [7:0] b;
      for (int i = 0; i < 9; i++)
         for (int j = 0; j < 4; j++)
         begin
            b = i < 7 ? 8'hAA : (i == 7 ? mrps_pkg::SFD_BYTE : v);
            @(posedge hclk);
            rx_i.non_idle <= 1'b1;
            rx_i.nib <= {2'h0, b[6-2*j], b[7-2*j]};
         end
      @(posedge hclk);
      chk("crs_dv", 32'h1, 32'(crs_dv));
      rx_i.non_idle <= 1'b0;
      rx_i.nib <= 4'h0;
      cyc(3);
   endtask : frm

   // cuts a hang short
   initial
   begin
      repeat (30000) @(posedge hclk);
      bad_count++;
      print_verdict();
   end

   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata, go} = '0;
      {half_duplex_i, link_act_i, link_speed_i, pme_req_i} = '0;
      {tx_symbol_bit4_pin, bad_count, checks_done} = '0;
      hsize = 3'h2;
      hresetn = 1'b0;
      sys_rst_pin_n = 1'b1;
      rx_i = '0;
      r = 32'($urandom(32'h9B2E));
      strap_pins = (6'($urandom) | 6'h20) & 6'h37;
      cyc(20);
      hresetn <= 1'b1;
      cyc(5);
      chk("opmode", 32'(strap_pins[2:0]), 32'(opmode));
      chk("core_regulator_disable_strap", 32'(strap_pins[4]), 32'(core_regulator_off));
      chk("rmii", 32'h0, 32'(rmii_mode));
      xf(1'b0, mrps_pkg::OFS_CTRL, 32'h0);
      chk("ctrl", 32'h00000004, r);
      xf(1'b0, mrps_pkg::OFS_STRAP, 32'h0);
      chk("strap reg", 32'(strap_pins), 32'(r[5:0]));
      xf(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, r);
      chk("hresp", 32'h0, 32'(hresp));
      // mii: collision and carrier follow the medium
      repeat (40)
      begin
         @(posedge hclk);
         rx_i <= 8'($urandom);
         d = 8'($urandom);
         cyc(2);
         chk("col", 32'(rx_i.collision), 32'(mii_col));
         chk("crs", 32'(rx_i.carrier), 32'(mii_crs));
         chk("mii rxd", 32'(rx_i.nib), 32'(rxd));
      end
      rx_i <= '0;
      xf(1'b1, mrps_pkg::OFS_STAT, 32'h0000000F);
      xf(1'b1, mrps_pkg::OFS_MASK, 32'h00000001);
      rx_i.collision <= 1'b1;
      {link_act_i, link_speed_i, pme_req_i} <= 3'($urandom);
      cyc(4);
      chk("irq", 32'h1, 32'(irq));
      chk("irq_n", 32'h0, 32'(irq_out_n));
      chk("irq pin", 32'h0, 32'({irq_pin_o, ~irq_pin_oe}));
      // each indicator code, interrupt pending
      for (int c = 0; c < 4; c++)
      begin
         xf(1'b1, mrps_pkg::OFS_CTRL, 32'({2'(c), 2'(c)}));
         cyc(2);
         e = c == 0 ? link_act_i : c == 1 ? link_speed_i : c == 3 && !pme_req_i;
         chk("ind a", 32'(e), 32'(indicator_out_a));
         chk("ind b", 32'(e), 32'(indicator_out_b));
      end
      xf(1'b1, mrps_pkg::OFS_STAT, 32'h00000001);
      cyc(2);
      chk("irq clr", 32'h0, 32'(irq));
      // system reset relatches straps: rmii, shared pin as tx bit 4
      @(posedge hclk);
      sys_rst_pin_n <= 1'b0;
      strap_pins <= (6'($urandom) | 6'h08) & 6'h1F;
      cyc(6);
      chk("pins oe", 32'h0, 32'(strap_pins_oe));
      sys_rst_pin_n <= 1'b1;
      tx_symbol_bit4_pin <= 1'b1;
      cyc(6);
      chk("pins oe2", 32'h1, 32'(strap_pins_oe));
      chk("opmode2", 32'(strap_pins[2:0]), 32'(opmode));
      chk("rmii2", 32'h1, 32'(rmii_mode));
      chk("tx_symbol_bit4", 32'h2, 32'({tx_symbol_bit4, irq_pin_oe}));
      xf(1'b1, mrps_pkg::OFS_CTRL, 32'h00000010);
      for (int p = 1; p >= 0; p--)
      begin
         pme_req_i <= 1'(p);
         cyc(4);
         chk("rxd2", 32'(!p), 32'(rxd[2]));
      end
      rx_i.ten_mb <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         d = k == 0 ? 8'hAB : 8'($urandom);
         n0 = nz;
         frm(d);
         chk("byte", 32'(d), 32'(lb));
         chk("dibits", 32'(nzd(d)), 32'(nz - n0));
      end
      half_duplex_i <= 1'b1;
      go <= 1'b1;
      n0 = nz;
      frm(8'hFF);
      chk("echo", 32'h0, 32'(nz - n0));
      print_verdict();
   end
endmodule : tb
